// *** core/bca_pkg.sv ***
/*
 * bca_pkg: shared constants of the breakpoint comparators A and B block:
 * register offsets, field positions, reset values and the operating mode type.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package bca_pkg;

    // ----------------------------------------------------------------
    // bus widths
    // ----------------------------------------------------------------
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 8;
    localparam int CORE_ADDR_W = 16;
    localparam int CORE_DATA_W = 16;
    localparam int EXT_ADDR_W = 20;
    localparam int PAGE_W = 6;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTL_ONE = 8'h20;
    localparam logic [7:0] OFS_CTL_TWO = 8'h21;
    localparam logic [7:0] OFS_CTL_THREE = 8'h29;
    localparam logic [7:0] OFS_A_EXT = 8'h2A;
    localparam logic [7:0] OFS_A_HIGH = 8'h2B;
    localparam logic [7:0] OFS_A_LOW = 8'h2C;
    localparam logic [7:0] OFS_B_EXT = 8'h2D;
    localparam logic [7:0] OFS_B_HIGH = 8'h2E;
    localparam logic [7:0] OFS_B_LOW = 8'h2F;
    localparam logic [7:0] OFS_STATUS = 8'h30;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTL1_TRC_EN_BIT = 7;
    localparam int CTL2_BRK_EN_BIT = 7;
    localparam int CTL2_FULL_BIT = 6;
    localparam int CTL3_A_MASK_HIGH_BIT = 7;
    localparam int CTL3_A_MASK_LOW_BIT = 6;
    localparam int CTL3_B_MASK_HIGH_BIT = 5;
    localparam int CTL3_B_MASK_LOW_BIT = 4;
    localparam int CTL3_A_DIR_EN_BIT = 3;
    localparam int CTL3_A_DIR_VAL_BIT = 2;
    localparam int CTL3_B_DIR_EN_BIT = 1;
    localparam int CTL3_B_DIR_VAL_BIT = 0;
    localparam int PG_SEL_LOW_BIT = 6;
    localparam int PG_SEL_HIGH_BIT = 7;
    localparam int STAT_A_BIT = 0;
    localparam int STAT_B_BIT = 1;
    localparam int STAT_FULL_BIT = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // operating mode
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {MODE_OFF, MODE_BRK, MODE_TRC} bca_mode_t;

endpackage

// *** core/bca_addr_cmp.sv ***
/*
 * bca_addr_cmp: combinational address comparator, used for comparator A and B.
 * Assumes the core bus signals are valid in the same cycle and the caller
 * gates the result by the operating mode.
 */
`timescale 1ns/100ps
`default_nettype none
module bca_addr_cmp
(
    input wire logic mode_brk_in,
    input wire logic [7:0] ext_reg_in,
    input wire logic [7:0] high_in,
    input wire logic [7:0] low_in,
    input wire logic mask_high_in,
    input wire logic mask_low_in,
    input wire logic dir_en_in,
    input wire logic dir_val_in,
    input wire logic [bca_pkg::CORE_ADDR_W-1:0] addr_in,
    input wire logic [bca_pkg::EXT_ADDR_W-1:0] ext_addr_in,
    input wire logic [bca_pkg::PAGE_W-1:0] page_in,
    input wire logic page_prog_in,
    input wire logic flash_in,
    input wire logic read_in,
    output logic match_out
);
    import bca_pkg::*;

    // ----------------------------------------------------------------
    // paging choice
    // ----------------------------------------------------------------
    // selector top bit never looked at
    wire logic paged = mode_brk_in ? flash_in : ext_reg_in[PG_SEL_LOW_BIT]; // R9 R10 R11 R13
    wire logic ext_use = paged & page_prog_in; // R6
    wire logic [5:0] ext_ref = mode_brk_in ? ext_addr_in[19:14] : page_in; // R11 R16
    wire logic ext_ok = !ext_use || (ext_reg_in[5:0] == ext_ref); // R16

    // ----------------------------------------------------------------
    // byte compares
    // ----------------------------------------------------------------
    wire logic top_ok = mode_brk_in || (high_in[7:6] == ext_addr_in[15:14]); // R13
    wire logic hi_paged_ok = top_ok && (high_in[5:0] == addr_in[13:8]); // R12
    wire logic hi_ok = paged ? hi_paged_ok : (high_in == addr_in[15:8]); // R12 R13 R15
    wire logic lo_ok = (low_in == addr_in[7:0]); // R15
    // 1:0 falls back to a full compare
    wire logic cmp_hi = !(mask_high_in && mask_low_in); // R4 R5 R17
    wire logic cmp_lo = !mask_low_in; // R4 R5 R17
    wire logic dir_ok = !dir_en_in || (dir_val_in == read_in); // R1 R2

    assign match_out = ext_ok && (!cmp_hi || hi_ok) && (!cmp_lo || lo_ok) && dir_ok; // R20

endmodule
`default_nettype wire

// *** core/bca_data_cmp.sv ***
/*
 * bca_data_cmp: combinational data comparator of comparator B in full mode.
 * Assumes the core data bus is valid in the cycle it is compared.
 */
`timescale 1ns/100ps
`default_nettype none
module bca_data_cmp
(
    input wire logic [7:0] high_in,
    input wire logic [7:0] low_in,
    input wire logic mask_high_in,
    input wire logic mask_low_in,
    input wire logic [bca_pkg::CORE_DATA_W-1:0] data_in,
    output logic match_out
);
    import bca_pkg::*;

    // ----------------------------------------------------------------
    // byte masked data compare
    // ----------------------------------------------------------------
    wire logic hi_ok = mask_high_in || (high_in == data_in[15:8]); // R7
    wire logic lo_ok = mask_low_in || (low_in == data_in[7:0]); // R7

    assign match_out = hi_ok && lo_ok; // R7

endmodule
`default_nettype wire

// *** core/bca_top.sv ***
/*
 * bca_top: breakpoint comparators A and B with their register file.
 * Assumes a core bus that presents address, data, page and direction with a
 * valid strobe, synchronous to clk_in, and a plain register port.
 */
// Contract
// R1 - comparator B uses bus direction only when its direction enable is 1.
// R2 - direction value 0 matches writes, 1 matches reads; ignored when disabled.
// R3 - in full mode comparator B direction bits have no effect.
// R4 - first mask x:0 compares all bytes; 0:1 skips low byte.
// R5 - second mask x:0 full, 0:1 skips low, 1:1 extended only.
// R6 - extended compare bits count only when a program page is selected.
// R7 - full mode B mask: 00 both, 01 high, 10 low, 11 none.
// R8 - in full mode B extended bits never take part.
// R9 - in debug mode page selector picks the paging kind.
// R10 - upper page selector bit is ignored.
// R11 - breakpoint mode: extended bits compare address 19:14 on flash access.
// R12 - breakpoint mode: non-flash high byte full, flash high 5:0 only.
// R13 - debug paging: high bits 7:6 compare extended address 15:14.
// R14 - software leaves page selector 00 in breakpoint mode.
// R15 - compare bits match address bits exactly; registers reset to zero.
// R16 - in debug mode extended bits compare against the core page signal.
// R17 - mask setting 1:0 acts as a full compare.
// R18 - breakpoint enable overrides debug enable; neither means inactive.
// R19 - full mode needs A address and B data match together.
// R20 - match reported for the bus cycle where all fields agree.
`timescale 1ns/100ps
`default_nettype none
module bca_top
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [bca_pkg::REG_ADDR_W-1:0] reg_addr_in,
    input wire logic [bca_pkg::REG_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [bca_pkg::REG_DATA_W-1:0] reg_rdata_out,
    input wire logic core_valid_in,
    input wire logic [bca_pkg::CORE_ADDR_W-1:0] core_address_bus_in,
    input wire logic [bca_pkg::CORE_DATA_W-1:0] core_data_in,
    input wire logic [bca_pkg::EXT_ADDR_W-1:0] extended_address_bus_in,
    input wire logic [bca_pkg::PAGE_W-1:0] program_page_in,
    input wire logic program_page_sel_in,
    input wire logic flash_access_in,
    input wire logic core_read_in,
    output logic match_a_out,
    output logic match_b_out,
    output logic full_match_out
);
    import bca_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] debug_control_one_r;
    logic [7:0] debug_control_two_r;
    logic [7:0] debug_control_three_r;
    logic [7:0] comparator_a_extended_r;
    logic [7:0] comparator_a_high_r;
    logic [7:0] comparator_a_low_r;
    logic [7:0] comparator_b_extended_r;
    logic [7:0] comparator_b_high_r;
    logic [7:0] comparator_b_low_r;
    logic [7:0] rdata_r;
    logic match_a_r;
    logic match_b_r;
    logic full_match_r;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    wire logic wr_ctl1 = reg_wr_in && hit(reg_addr_in, OFS_CTL_ONE);
    wire logic wr_ctl2 = reg_wr_in && hit(reg_addr_in, OFS_CTL_TWO);
    wire logic wr_ctl3 = reg_wr_in && hit(reg_addr_in, OFS_CTL_THREE);
    wire logic wr_a_ext = reg_wr_in && hit(reg_addr_in, OFS_A_EXT);
    wire logic wr_a_high = reg_wr_in && hit(reg_addr_in, OFS_A_HIGH);
    wire logic wr_a_low = reg_wr_in && hit(reg_addr_in, OFS_A_LOW);
    wire logic wr_b_ext = reg_wr_in && hit(reg_addr_in, OFS_B_EXT);
    wire logic wr_b_high = reg_wr_in && hit(reg_addr_in, OFS_B_HIGH);
    wire logic wr_b_low = reg_wr_in && hit(reg_addr_in, OFS_B_LOW);

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    wire logic trace_debug_enable = debug_control_one_r[CTL1_TRC_EN_BIT];
    wire logic breakpoint_mode_enable = debug_control_two_r[CTL2_BRK_EN_BIT];
    wire logic first_addr_mask_high = debug_control_three_r[CTL3_A_MASK_HIGH_BIT];
    wire logic first_addr_mask_low = debug_control_three_r[CTL3_A_MASK_LOW_BIT];
    wire logic second_mask_high = debug_control_three_r[CTL3_B_MASK_HIGH_BIT];
    wire logic second_mask_low = debug_control_three_r[CTL3_B_MASK_LOW_BIT];
    wire logic cmp_a_dir_enable = debug_control_three_r[CTL3_A_DIR_EN_BIT];
    wire logic cmp_a_dir_value = debug_control_three_r[CTL3_A_DIR_VAL_BIT];
    wire logic cmp_b_dir_enable = debug_control_three_r[CTL3_B_DIR_EN_BIT];
    wire logic cmp_b_dir_value = debug_control_three_r[CTL3_B_DIR_VAL_BIT];

    // ----------------------------------------------------------------
    // mode select
    // ----------------------------------------------------------------
    // breakpoint enable wins over debug enable
    wire bca_mode_t mode = breakpoint_mode_enable ? MODE_BRK : // R18
        (trace_debug_enable ? MODE_TRC : MODE_OFF); // R18
    wire logic mode_brk = (mode == MODE_BRK);
    wire logic active = (mode != MODE_OFF) && core_valid_in; // R18
    wire logic full_mode = mode_brk && debug_control_two_r[CTL2_FULL_BIT];
    // direction bits of B dropped in full mode
    wire logic b_dir_en = cmp_b_dir_enable && !full_mode; // R3

    // ----------------------------------------------------------------
    // comparators
    // ----------------------------------------------------------------
    logic a_addr_hit;
    logic b_addr_hit;
    logic b_data_hit;

    bca_addr_cmp u_cmp_a
    (
        .mode_brk_in(mode_brk),
        .ext_reg_in(comparator_a_extended_r),
        .high_in(comparator_a_high_r),
        .low_in(comparator_a_low_r),
        .mask_high_in(first_addr_mask_high),
        .mask_low_in(first_addr_mask_low),
        .dir_en_in(cmp_a_dir_enable),
        .dir_val_in(cmp_a_dir_value),
        .addr_in(core_address_bus_in),
        .ext_addr_in(extended_address_bus_in),
        .page_in(program_page_in),
        .page_prog_in(program_page_sel_in),
        .flash_in(flash_access_in),
        .read_in(core_read_in),
        .match_out(a_addr_hit)
    );

    bca_addr_cmp u_cmp_b
    (
        .mode_brk_in(mode_brk),
        .ext_reg_in(comparator_b_extended_r),
        .high_in(comparator_b_high_r),
        .low_in(comparator_b_low_r),
        .mask_high_in(second_mask_high),
        .mask_low_in(second_mask_low),
        .dir_en_in(b_dir_en),
        .dir_val_in(cmp_b_dir_value),
        .addr_in(core_address_bus_in),
        .ext_addr_in(extended_address_bus_in),
        .page_in(program_page_in),
        .page_prog_in(program_page_sel_in),
        .flash_in(flash_access_in),
        .read_in(core_read_in),
        .match_out(b_addr_hit)
    );

    // extended bits of B not wired in here
    bca_data_cmp u_data_b
    (
        .high_in(comparator_b_high_r),
        .low_in(comparator_b_low_r),
        .mask_high_in(second_mask_high),
        .mask_low_in(second_mask_low),
        .data_in(core_data_in),
        .match_out(b_data_hit) // R8
    );

    // ----------------------------------------------------------------
    // match results
    // ----------------------------------------------------------------
    wire logic match_a_nxt = active && a_addr_hit; // R20
    wire logic match_b_nxt = active && (full_mode ? b_data_hit : b_addr_hit); // R3 R7 R20
    wire logic full_match_nxt = full_mode && match_a_nxt && match_b_nxt; // R19

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire logic [7:0] status = {5'h00, full_match_r, match_b_r, match_a_r};
    wire logic [7:0] rsel =
        hit(reg_addr_in, OFS_CTL_ONE) ? debug_control_one_r :
        hit(reg_addr_in, OFS_CTL_TWO) ? debug_control_two_r :
        hit(reg_addr_in, OFS_CTL_THREE) ? debug_control_three_r :
        hit(reg_addr_in, OFS_A_EXT) ? comparator_a_extended_r :
        hit(reg_addr_in, OFS_A_HIGH) ? comparator_a_high_r :
        hit(reg_addr_in, OFS_A_LOW) ? comparator_a_low_r :
        hit(reg_addr_in, OFS_B_EXT) ? comparator_b_extended_r :
        hit(reg_addr_in, OFS_B_HIGH) ? comparator_b_high_r :
        hit(reg_addr_in, OFS_B_LOW) ? comparator_b_low_r :
        hit(reg_addr_in, OFS_STATUS) ? status : 8'h00;
    wire logic [7:0] rdata_nxt = reg_rd_in ? rsel : 8'h00;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            debug_control_one_r <= REG_RESET;
            debug_control_two_r <= REG_RESET;
            debug_control_three_r <= REG_RESET;
            comparator_a_extended_r <= REG_RESET; // R15
            comparator_a_high_r <= REG_RESET; // R15
            comparator_a_low_r <= REG_RESET; // R15
            comparator_b_extended_r <= REG_RESET;
            comparator_b_high_r <= REG_RESET;
            comparator_b_low_r <= REG_RESET;
        end
        else
        begin
            if (wr_ctl1)
                debug_control_one_r <= reg_wdata_in;
            if (wr_ctl2)
                debug_control_two_r <= reg_wdata_in;
            if (wr_ctl3)
                debug_control_three_r <= reg_wdata_in;
            if (wr_a_ext)
                comparator_a_extended_r <= reg_wdata_in;
            if (wr_a_high)
                comparator_a_high_r <= reg_wdata_in;
            if (wr_a_low)
                comparator_a_low_r <= reg_wdata_in;
            if (wr_b_ext)
                comparator_b_extended_r <= reg_wdata_in;
            if (wr_b_high)
                comparator_b_high_r <= reg_wdata_in;
            if (wr_b_low)
                comparator_b_low_r <= reg_wdata_in;
        end
    end

    // ----------------------------------------------------------------
    // output flops
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rdata_r <= 8'h00;
            match_a_r <= 1'b0;
            match_b_r <= 1'b0;
            full_match_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            match_a_r <= match_a_nxt;
            match_b_r <= match_b_nxt;
            full_match_r <= full_match_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign match_a_out = match_a_r;
    assign match_b_out = match_b_r;
    assign full_match_out = full_match_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    wire logic b_plain = (mode != MODE_OFF) && !full_mode && core_valid_in;
    wire logic trc_flat = (mode == MODE_TRC) && !comparator_a_extended_r[PG_SEL_LOW_BIT];

    property p_dir_b;
        b_plain && cmp_b_dir_enable && cmp_b_dir_value && !core_read_in |=> !match_b_out;
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("b matched wrong direction"); // R1 R2

    property p_full_dir;
        full_mode && core_valid_in && !second_mask_high && !second_mask_low
            && core_data_in == {comparator_b_high_r, comparator_b_low_r} |=> match_b_out;
    endproperty
    a_full_dir: assert property (p_full_dir) else $error("full data match missed"); // R3 R7

    property p_range_a;
        trc_flat && core_valid_in && !cmp_a_dir_enable && !first_addr_mask_high
            && first_addr_mask_low && comparator_a_high_r == core_address_bus_in[15:8]
            |=> match_a_out;
    endproperty
    a_range_a: assert property (p_range_a) else $error("a range match missed"); // R4

    property p_wide_b;
        b_plain && (mode == MODE_TRC) && !comparator_b_extended_r[PG_SEL_LOW_BIT]
            && !cmp_b_dir_enable && second_mask_high && second_mask_low |=> match_b_out;
    endproperty
    a_wide_b: assert property (p_wide_b) else $error("b open range missed"); // R5

    property p_low_mask;
        (mode != MODE_OFF) && first_addr_mask_high && !first_addr_mask_low
            && comparator_a_low_r != core_address_bus_in[7:0] |=> !match_a_out;
    endproperty
    a_low_mask: assert property (p_low_mask) else $error("mask 1:0 not full"); // R17

    property p_nocmp;
        full_mode && core_valid_in && second_mask_high && second_mask_low |=> match_b_out;
    endproperty
    a_nocmp: assert property (p_nocmp) else $error("full mode b 1:1 missed"); // R8

    property p_brk_high;
        mode_brk && !flash_access_in && !first_addr_mask_low
            && comparator_a_high_r != core_address_bus_in[15:8] |=> !match_a_out;
    endproperty
    a_brk_high: assert property (p_brk_high) else $error("non-flash high byte"); // R12

    property p_off;
        (mode == MODE_OFF) |=> !match_a_out && !match_b_out && !full_match_out;
    endproperty
    a_off: assert property (p_off) else $error("match while inactive"); // R18

    property p_full_pair;
        full_match_out |-> match_a_out && match_b_out && $past(full_mode);
    endproperty
    a_full_pair: assert property (p_full_pair) else $error("full match unpaired"); // R19

    property p_ext_a;
        mode_brk && core_valid_in && flash_access_in && program_page_sel_in
            && comparator_a_extended_r[5:0] != extended_address_bus_in[19:14]
            |=> !match_a_out;
    endproperty
    a_ext_a: assert property (p_ext_a) else $error("page compare ignored"); // R6 R11

    property p_page_a;
        (mode == MODE_TRC) && comparator_a_extended_r[PG_SEL_LOW_BIT] && !first_addr_mask_low
            && comparator_a_high_r[7:6] != extended_address_bus_in[15:14] |=> !match_a_out;
    endproperty
    a_page_a: assert property (p_page_a) else $error("a paged high bits ignored"); // R13

    property p_page_ext;
        (mode == MODE_TRC) && comparator_a_extended_r[PG_SEL_LOW_BIT] && program_page_sel_in
            && comparator_a_extended_r[5:0] != program_page_in |=> !match_a_out;
    endproperty
    a_page_ext: assert property (p_page_ext) else $error("page compare missed"); // R6 R16

    property p_flash_b;
        mode_brk && !full_mode && flash_access_in && !second_mask_low
            && comparator_b_high_r[5:0] != core_address_bus_in[13:8] |=> !match_b_out;
    endproperty
    a_flash_b: assert property (p_flash_b) else $error("b flash high byte"); // R11 R12

endmodule
`default_nettype wire

// *** test/bca_core_model.sv ***
/*
 * bca_core_model: processor core bus model driving address, data, page and direction.
 * Assumes the bench calls drive and release_bus right after a rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module bca_core_model
(
    output logic valid_out,
    output logic [15:0] addr_out,
    output logic [15:0] data_out,
    output logic [19:0] xaddr_out,
    output logic [5:0] page_out,
    output logic page_sel_out,
    output logic flash_out,
    output logic read_out
);
    initial
    begin
        {valid_out, addr_out, data_out, xaddr_out, page_out, page_sel_out} = '0;
        {flash_out, read_out} = 2'b00;
    end
    // one bus cycle, held until the next edge
    task automatic drive(input logic [15:0] a, input logic [15:0] d, input logic [19:0] x,
                         input logic [5:0] p, input logic [3:0] vsfr);
        {addr_out, data_out, xaddr_out, page_out} <= {a, d, x, p};
        {valid_out, page_sel_out, flash_out, read_out} <= vsfr;
    endtask
    // valid drops low; the other released lines show the inverse of their last value
    task automatic release_bus();
        valid_out <= 1'b0;
        {addr_out, data_out, xaddr_out, page_out} <= ~{addr_out, data_out, xaddr_out, page_out};
        {page_sel_out, flash_out, read_out} <= ~{page_sel_out, flash_out, read_out};
    endtask
endmodule
`default_nettype wire

// *** test/bca_tb_top.sv ***
/*
 * bca_tb_top: self-checking bench of the breakpoint comparators with random setups.
 * Assumes bca_top, bca_pkg and the core bus model are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
module bca_tb_top;
    import bca_pkg::*;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    wire logic [2:0] m_out;
    wire logic vld, psel, fla, rdc;
    wire logic [15:0] ca, cd;
    wire logic [19:0] cx;
    wire logic [5:0] cp;
    int fail_count = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'hBFA7B54F;
    logic [7:0] cr [9];
    logic [7:0] ofs [9] = '{OFS_CTL_ONE, OFS_CTL_TWO, OFS_CTL_THREE, OFS_A_EXT, OFS_A_HIGH,
                            OFS_A_LOW, OFS_B_EXT, OFS_B_HIGH, OFS_B_LOW};
    logic [15:0] ad, dt;
    logic [19:0] xa;
    logic [5:0] pp;
    logic [3:0] vsfr;
    logic [2:0] em;
    always #5 clk_in = ~clk_in;
    bca_core_model core(.valid_out(vld), .addr_out(ca), .data_out(cd), .xaddr_out(cx),
        .page_out(cp), .page_sel_out(psel), .flash_out(fla), .read_out(rdc));
    bca_top dut(.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .core_valid_in(vld), .core_address_bus_in(ca),
        .core_data_in(cd), .extended_address_bus_in(cx), .program_page_in(cp),
        .program_page_sel_in(psel), .flash_access_in(fla), .core_read_in(rdc),
        .match_a_out(m_out[0]), .match_b_out(m_out[1]), .full_match_out(m_out[2]));
    // ----------------------------------------------------------------
    // expectation and random functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic acmp(input logic [7:0] ex, input logic [7:0] hi,
                                  input logic [7:0] lo, input logic [3:0] mk);
        logic eok, hok;
        if (cr[1][7])
        begin
            eok = !(vsfr[1] && vsfr[2]) || ex[5:0] == xa[19:14];
            hok = vsfr[1] ? hi[5:0] == ad[13:8] : hi == ad[15:8];
        end
        else
        begin
            eok = !ex[6] || !vsfr[2] || ex[5:0] == pp;
            hok = ex[6] ? hi == {xa[15:14], ad[13:8]} : hi == ad[15:8];
        end
        return eok && (&mk[3:2] || hok) && (mk[2] || lo == ad[7:0])
            && (!mk[1] || mk[0] == vsfr[0]);
    endfunction
    function automatic logic [2:0] expect_m();
        logic on, full, ma, bd, mb;
        on = vsfr[3] && (cr[1][7] || cr[0][7]);
        full = cr[1][7] && cr[1][6];
        ma = on && acmp(cr[3], cr[4], cr[5], {cr[2][7:6], cr[2][3:2]});
        bd = (cr[2][5] || cr[7] == dt[15:8]) && (cr[2][4] || cr[8] == dt[7:0]);
        mb = on && (full ? bd : acmp(cr[6], cr[7], cr[8], {cr[2][5:4], cr[2][1:0]}));
        return {full && ma && bd, mb, ma};
    endfunction
    // ----------------------------------------------------------------
    // compare, register bus and stimulus tasks
    // ----------------------------------------------------------------
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_one(input logic [7:0] a, input logic [7:0] d);
        {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        {reg_addr_in, reg_rd_in} <= {a, 1'b1};
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk_val(reg_rdata_out, exp);
    endtask
    task automatic gen_setup();
        logic [31:0] g, h;
        {dt, ad} = xs();
        g = xs();
        {vsfr, pp, xa} = {g[31:29] != 3'h0, g[28:26], g[25:0]};
        h = xs();
        g = xs();
        {cr[0], cr[1], cr[2]} = g[23:0];
        g = xs();
        if (h[0]) xa[15:14] = ad[15:14];
        cr[3] = h[1] ? {g[7:6], cr[1][7] ? xa[19:14] : pp} : g[7:0];
        cr[6] = h[2] ? {g[15:14], cr[1][7] ? xa[19:14] : pp} : g[15:8];
        // page selector kept at 00 in breakpoint mode
        if (cr[1][7]) {cr[3][7:6], cr[6][7:6]} = 4'h0;
        cr[4] = h[3] ? ad[15:8] : g[23:16];
        cr[5] = h[4] ? ad[7:0] : g[31:24];
        cr[7] = h[5] ? (h[6] ? dt[15:8] : ad[15:8]) : h[31:24];
        cr[8] = h[7] ? (h[8] ? dt[7:0] : ad[7:0]) : h[23:16];
        for (int i = 0; i < 9; i++)
        begin
            {reg_addr_in, reg_wdata_in, reg_wr_in} <= {ofs[i], cr[i], 1'b1};
            @(posedge clk_in);
        end
        reg_wr_in <= 1'b0;
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #150000;
        fail_count++;
        final_report();
    end
    initial
    begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        for (int i = 0; i < 9; i++) rd_chk(ofs[i], REG_RESET);
        wr_one(8'h40, 8'h5A);
        rd_chk(8'h40, 8'h00);
        wr_one(OFS_STATUS, 8'hFF);
        rd_chk(OFS_STATUS, 8'h00);
        $display("test registers done");
        for (int n = 0; n < 400; n++)
        begin
            gen_setup();
            rd_chk(ofs[n % 9], cr[n % 9]);
            core.drive(ad, dt, xa, pp, vsfr);
            @(posedge clk_in);
            core.release_bus();
            #1 em = expect_m();
            chk_val({7'h00, m_out[0]}, {7'h00, em[0]});
            chk_val({7'h00, m_out[1]}, {7'h00, em[1]});
            chk_val({7'h00, m_out[2]}, {7'h00, em[2]});
            rd_chk(OFS_STATUS, {5'h00, em});
            chk_val({5'h00, m_out}, 8'h00);
        end
        $display("test random matches done");
        final_report();
    end
endmodule
`default_nettype wire
